// ### verilog/timer8_compare_waveform.sv
// Our own choices: the plain strobed port and the address map.
module timer8_compare_waveform #(
    parameter int TICK_DIV = timer8_pkg::TICK_DIV_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [timer8_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [7:0] rdata_o,
    output logic pin_out_o,
    output logic pin_oe_n_o
);
    import timer8_pkg::*;

    // A divider of zero would never produce a timer tick.
    if (TICK_DIV < 1) begin : g_bad_div
        $error("TICK_DIV must be at least one");
    end

    // ------------------------------------------------------------------
    // Timer tick divider
    // ------------------------------------------------------------------
    localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;
    ctrl_t ctrl_q, ctrl_d;

    always_comb begin
        div_d = div_q;
        tick_d = 1'b0;
        if (ctrl_q.run) begin
            if (div_q == DIV_LAST) begin
                div_d = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + 1'b1;
            end
        end else begin
            div_d = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // ------------------------------------------------------------------
    // Counter, compare and waveform state
    // ------------------------------------------------------------------
    logic [7:0] count_q, count_d;
    logic [7:0] cmp_buf_q, cmp_buf_d;
    logic [7:0] cmp_act_q, cmp_act_d;
    logic block_q, block_d;
    logic oc_q, oc_d;
    logic ovf_q, ovf_d;
    logic cmpf_q, cmpf_d;
    logic pin_q, pin_d;
    logic oe_n_q, oe_n_d;
    logic [7:0] rdata_q, rdata_d;

    logic wr_ctrl, wr_count, wr_cmp, wr_flags;
    logic match, wrap, pwm_mode, force_hit;
    logic ovf_set;
    output_action_t force_act;

    function automatic logic apply_action(input output_action_t act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            ACT_NONE: res = cur;
            ACT_TOGGLE: res = ~cur;
            ACT_CLEAR: res = 1'b0;
            ACT_SET: res = 1'b1;
        endcase
        return res;
    endfunction : apply_action

    // ------------------------------------------------------------------
    // Bus decode and timer events
    // ------------------------------------------------------------------
    always_comb begin
        wr_ctrl = write_i && (addr_i == OFF_CTRL);
        wr_count = write_i && (addr_i == OFF_COUNT);
        wr_cmp = write_i && (addr_i == OFF_COMPARE);
        wr_flags = write_i && (addr_i == OFF_FLAGS);
        pwm_mode = ctrl_q.waveform_mode_select[0];
        match = tick_q && !block_q && (count_q == cmp_act_q);
        wrap = tick_q && (count_q == COUNT_MAX);
        // The mode written beside the strobe decides, so one write can set up and force.
        force_hit = wr_ctrl && wdata_i[CTRL_FORCE_BIT] && !wdata_i[CTRL_MODE_LSB];
        force_act = output_action_t'(wdata_i[CTRL_ACTION_LSB +: 2]);
        // The unsupported dual-slope mode holds the counter, so it never overflows.
        ovf_set = wrap && (ctrl_q.waveform_mode_select != MODE_PHASE_CORRECT);
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        // Mode changes leave the output state alone.
        if (wr_ctrl) begin
            ctrl_d.waveform_mode_select = waveform_mode_t'(wdata_i[CTRL_MODE_LSB +: 2]);
            ctrl_d.output_action_select = output_action_t'(wdata_i[CTRL_ACTION_LSB +: 2]);
            ctrl_d.pin_direction_bit = wdata_i[CTRL_DIR_BIT];
            ctrl_d.port_data = wdata_i[CTRL_PORT_BIT];
            ctrl_d.run = wdata_i[CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Compare value and its buffer
    // ------------------------------------------------------------------
    always_comb begin
        cmp_buf_d = cmp_buf_q;
        cmp_act_d = cmp_act_q;
        if (wrap && (ctrl_q.waveform_mode_select == MODE_FAST_PWM)) begin
            cmp_act_d = cmp_buf_q;
        end
        if (wr_cmp) begin
            cmp_buf_d = wdata_i;
            if (!pwm_mode) begin
                cmp_act_d = wdata_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_buf_q <= COMPARE_RESET;
            cmp_act_q <= COMPARE_RESET;
        end else begin
            cmp_buf_q <= cmp_buf_d;
            cmp_act_q <= cmp_act_d;
        end
    end

    // ------------------------------------------------------------------
    // Counter and compare output state
    // ------------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        block_d = block_q;
        oc_d = oc_q;
        if (tick_q) begin
            block_d = 1'b0;
            unique case (ctrl_q.waveform_mode_select)
                MODE_NORMAL: begin
                    count_d = count_q + 8'h01;
                    if (match) begin
                        oc_d = apply_action(ctrl_q.output_action_select, oc_q);
                    end
                end
                MODE_CLEAR_ON_MATCH: begin
                    if (match) begin
                        count_d = COUNT_BOTTOM;
                        oc_d = apply_action(ctrl_q.output_action_select, oc_q);
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                MODE_FAST_PWM: begin
                    count_d = count_q + 8'h01;
                    if (match) begin
                        oc_d = apply_action(ctrl_q.output_action_select, oc_q);
                    end
                    if (wrap) begin
                        // Bottom wins over a match at maximum, giving a steady level.
                        if (ctrl_q.output_action_select == ACT_CLEAR) begin
                            oc_d = 1'b1;
                        end else if (ctrl_q.output_action_select == ACT_SET) begin
                            oc_d = 1'b0;
                        end
                    end
                end
                MODE_PHASE_CORRECT: begin
                    count_d = count_q;
                end
            endcase
        end

        // A forced compare acts on the output state only.
        if (force_hit) begin
            oc_d = apply_action(force_act, oc_q);
        end

        // A counter write beats counting and clearing, and masks a match at the next tick.
        if (wr_count) begin
            count_d = wdata_i;
            block_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= COUNT_RESET;
            block_q <= 1'b0;
            oc_q <= 1'b0;
        end else begin
            count_q <= count_d;
            block_q <= block_d;
            oc_q <= oc_d;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_comb begin
        ovf_d = ovf_q;
        cmpf_d = cmpf_q;
        if (wr_flags && wdata_i[FLAG_OVF_BIT]) begin
            ovf_d = 1'b0;
        end
        if (wr_flags && wdata_i[FLAG_CMP_BIT]) begin
            cmpf_d = 1'b0;
        end
        // A hardware set in the same cycle wins over the clear.
        if (ovf_set) begin
            ovf_d = 1'b1;
        end
        if (match) begin
            cmpf_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ovf_q <= 1'b0;
            cmpf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
            cmpf_q <= cmpf_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin output and direction
    // ------------------------------------------------------------------
    always_comb begin
        if (ctrl_d.output_action_select != ACT_NONE) begin
            pin_d = oc_d;
        end else begin
            pin_d = ctrl_d.port_data;
        end
        oe_n_d = ~ctrl_d.pin_direction_bit;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (read_i) begin
            unique case (addr_i)
                OFF_CTRL: rdata_d = {1'b0, ctrl_q.run, ctrl_q.port_data,
                    ctrl_q.pin_direction_bit, ctrl_q.output_action_select,
                    ctrl_q.waveform_mode_select};
                OFF_COUNT: rdata_d = count_q;
                OFF_COMPARE: rdata_d = cmp_buf_q;
                OFF_FLAGS: rdata_d = {6'b00_0000, cmpf_q, ovf_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Read data stand for one cycle only, so the bus sees zero when idle.
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign pin_out_o = pin_q;
    assign pin_oe_n_o = oe_n_q;

endmodule : timer8_compare_waveform

// ### verilog/timer8_pkg.sv
package timer8_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_COUNT = 3'h1;
    localparam logic [2:0] OFF_COMPARE = 3'h2;
    localparam logic [2:0] OFF_FLAGS = 3'h3;

    // ------------------------------------------------------------------
    // Control and flag register field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTION_LSB = 2;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_PORT_BIT = 5;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_FORCE_BIT = 7;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_BIT = 1;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam int TICK_DIV_DEFAULT = 1;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'd0,
        MODE_PHASE_CORRECT = 2'd1,
        MODE_CLEAR_ON_MATCH = 2'd2,
        MODE_FAST_PWM = 2'd3
    } waveform_mode_t;

    typedef enum logic [1:0] {
        ACT_NONE = 2'd0,
        ACT_TOGGLE = 2'd1,
        ACT_CLEAR = 2'd2,
        ACT_SET = 2'd3
    } output_action_t;

    typedef struct packed {
        logic run;
        logic port_data;
        logic pin_direction_bit;
        output_action_t output_action_select;
        waveform_mode_t waveform_mode_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, ACT_NONE, MODE_NORMAL};

endpackage : timer8_pkg

// ### dv/pin_load_model.sv
module pin_load_model (
    input wire logic ref_clk_i,
    input wire logic pin_out_i,
    input wire logic pin_oe_n_i,
    input wire logic clr_i,
    output logic level_o,
    output logic [15:0] high_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // The load pulls the line low whenever the pin is not driven.
    assign level_o = !pin_oe_n_i && pin_out_i;
    always_ff @(posedge ref_clk_i) begin
        if (clr_i) begin
            high_cnt_o <= 16'h0000;
        end else begin
            high_cnt_o <= high_cnt_o + {15'h0000, level_o};
        end
    end
endmodule : pin_load_model

// ### dv/timer8_chk.sv
module timer8_chk #(
    parameter int TICK_DIV = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [timer8_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [7:0] rdata_o,
    input wire logic pin_out_o,
    input wire logic pin_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import timer8_pkg::*;
    logic cw;
    logic run_ok;
    logic [7:0] ctl_q;
    logic [7:0] cmp_q;
    assign cw = write_i && addr_i == OFF_CTRL;
    assign run_ok = ctl_q[6] && ctl_q[1:0] != 2'h1 && TICK_DIV == 1;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl_q <= 8'h00;
            cmp_q <= 8'h00;
        end else begin
            if (cw) begin
                ctl_q <= wdata_i;
            end
            if (write_i && addr_i == OFF_COMPARE) begin
                cmp_q <= wdata_i;
            end
        end
    end
    function automatic logic [7:0] nxt(input logic [7:0] c);
        if (ctl_q[1:0] == 2'h2 && c == cmp_q) begin
            return 8'h00;
        end
        return c + 8'h01;
    endfunction : nxt
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_two_rd;
        (!write_i && run_ok) ##1 (read_i && addr_i == OFF_COUNT) [*2];
    endsequence
    property p_count_step;
        s_two_rd |=> rdata_o == nxt($past(rdata_o));
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");
    property p_oe_set;
        cw |=> pin_oe_n_o == !$past(wdata_i[4]);
    endproperty
    a_oe_set: assert property (p_oe_set) else $error("enable not from direction");
    property p_oe_hold;
        !cw |=> $stable(pin_oe_n_o);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
    property p_port_src;
        cw && wdata_i[3:2] == 2'h0 |=> pin_out_o == $past(wdata_i[5]);
    endproperty
    a_port_src: assert property (p_port_src) else $error("pin not from port");
    property p_no_act;
        !cw && ctl_q[3:2] == 2'h0 |=> $stable(pin_out_o);
    endproperty
    a_no_act: assert property (p_no_act) else $error("pin moved with no action");
    property p_force;
        cw && wdata_i[7] && !wdata_i[0] && wdata_i[3] |=> pin_out_o == $past(wdata_i[2]);
    endproperty
    a_force: assert property (p_force) else $error("force not applied");
    property p_mode_keep;
        cw && wdata_i[7:6] == 2'h0 && wdata_i[3:2] != 2'h0 && ctl_q[3:2] != 2'h0 && !ctl_q[6]
            |=> $stable(pin_out_o);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("state lost on mode change");
    property p_rd_idle;
        !read_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_unmap;
        read_i && addr_i[2] |=> rdata_o == 8'h00;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
endmodule : timer8_chk

bind timer8_compare_waveform timer8_chk #(.TICK_DIV(TICK_DIV)) u_chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o));

// ### dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timer8_pkg::*;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    row_t rows [5] = '{'{OFF_COMPARE, 8'h5a, 8'h5a}, '{OFF_COUNT, 8'h33, 8'h33},
        '{OFF_CTRL, 8'h9e, 8'h1e}, '{3'h5, 8'hff, 8'h00}, '{OFF_FLAGS, 8'h03, 8'h00}};
    row_t pwm [4] = '{'{3'h2, 8'h40, 8'h41}, '{3'h3, 8'h40, 8'hbf},
        '{3'h3, 8'hff, 8'h00}, '{3'h2, 8'h00, 8'h01}};
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic clr = 1'b0;
    logic [7:0] rdata_o;
    logic pin_out_o;
    logic pin_oe_n_o;
    logic [15:0] high_cnt;
    logic [7:0] v;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    timer8_compare_waveform #(.TICK_DIV(1)) DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
    pin_load_model u_load (.ref_clk_i(ref_clk_i), .pin_out_i(pin_out_o),
        .pin_oe_n_i(pin_oe_n_o), .clr_i(clr), .level_o(), .high_cnt_o(high_cnt));
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge ref_clk_i);
        write_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge ref_clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge ref_clk_i);
        read_i <= 1'b0;
        #1;
        r = rdata_o;
    endtask : rd
    // Two reads of the counter back to back, judged by the checker.
    task automatic burst();
        @(posedge ref_clk_i);
        addr_i <= OFF_COUNT;
        read_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        read_i <= 1'b0;
    endtask : burst
    // Counts driven-high cycles over a window of 256 clock cycles.
    task automatic meas(input logic [15:0] e);
        @(posedge ref_clk_i);
        clr <= 1'b1;
        @(posedge ref_clk_i);
        clr <= 1'b0;
        repeat (256) @(posedge ref_clk_i);
        #1;
        chk(high_cnt, e);
    endtask : meas
    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk({8'h00, v}, {8'h00, rows[i].e});
        end
        chk({14'h0000, pin_oe_n_o, pin_out_o}, 16'h0001);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        chk({14'h0000, pin_oe_n_o, pin_out_o}, 16'h0002);
        for (int a = 0; a < 4; a++) begin
            rd(a[2:0], v);
            chk({8'h00, v}, 16'h0000);
        end
        wr(OFF_CTRL, 8'h8c);
        wr(OFF_CTRL, 8'h1c);
        chk({14'h0000, pin_oe_n_o, pin_out_o}, 16'h0001);
        wr(OFF_CTRL, 8'h1d);
        chk({15'h0000, pin_out_o}, 16'h0001);
        wr(OFF_CTRL, 8'h88);
        chk({14'h0000, pin_oe_n_o, pin_out_o}, 16'h0002);
        wr(OFF_COMPARE, 8'h10);
        wr(OFF_COUNT, 8'h10);
        wr(OFF_CTRL, 8'h40);
        burst();
        wr(OFF_CTRL, 8'h00);
        rd(OFF_FLAGS, v);
        chk({8'h00, v}, 16'h0000);
        wr(OFF_COUNT, 8'h0e);
        wr(OFF_CTRL, 8'h40);
        repeat (4) @(posedge ref_clk_i);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_FLAGS, v);
        chk({8'h00, v}, 16'h0002);
        wr(OFF_FLAGS, 8'h02);
        rd(OFF_FLAGS, v);
        chk({8'h00, v}, 16'h0000);
        wr(OFF_COUNT, 8'hf0);
        wr(OFF_CTRL, 8'h40);
        burst();
        repeat (16) @(posedge ref_clk_i);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_FLAGS, v);
        chk({8'h00, v}, 16'h0001);
        rd(OFF_COUNT, v);
        chk({15'h0000, v < 8'h10}, 16'h0001);
        wr(OFF_COMPARE, 8'h03);
        wr(OFF_COUNT, 8'h00);
        wr(OFF_CTRL, 8'h56);
        burst();
        meas(16'h0080);
        wr(OFF_COUNT, 8'h20);
        burst();
        foreach (pwm[i]) begin
            wr(OFF_COMPARE, pwm[i].d);
            wr(OFF_CTRL, 8'h53 | {4'h0, pwm[i].a[1:0], 2'h0});
            burst();
            repeat (300) @(posedge ref_clk_i);
            meas({8'h00, pwm[i].e});
        end
        wr(OFF_FLAGS, 8'h03);
        repeat (260) @(posedge ref_clk_i);
        rd(OFF_FLAGS, v);
        chk({8'h00, v}, 16'h0003);
        close_out();
    end
endmodule : tb_top
